//--- rtl/pgs_device.sv
// pgs_device: generator end; link registers, oscillator sync, pwm counter.
// assumes link pins are asynchronous and slower than aclk / 4.
//
// Overview of operation
// - bit 15 reads parity when enabled
// - enable bit starts and stops generator
// - direction: updown, up, down, no action
// - sync codes 0, 3, 4 disable sync
// - code 1 measures sync pulse period
// - code 2 sync pulse sets period
// - code 5 locks to 20 kHz pulse
// - code 6 locks and sets period
// - code 7 locks oscillator to sclk
// - rate field names sclk frequency
// - cycle count field sets sync window
// - spread spectrum off bit, reset one
// - drive scheme field selects input mode
// - scheme reset value depends on variant
// - system bit enables link parity
`default_nettype none
module pgs_device #(
  parameter bit PWM_OVER_LINK = 1'b1
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  pgs_link_if.dev          link,
  output logic             gen_on,
  output logic [1:0]       counter_direction,
  output logic [15:0]      pwm_count,
  output logic             pwm_out,
  output logic             osc_locked,
  output logic             spread_spectrum_off,
  output logic [1:0]       drive_scheme,
  output logic             parity_on
);
  logic [2:0]  sclk_s, cs_s, sync_s, src;
  logic [1:0]  mosi_s, dir;
  logic [4:0]  bit_q;
  logic [23:0] rx_q, rx_nx;
  logic [15:0] tx_q, rdv, pwmg_q, cfg1_q, drv_q, sys_q, cnt_q, top;
  logic [15:0] period_q, per_cnt_q, win_q, win_exp, win_tol;
  logic [14:0] meas_q;
  logic [9:0]  edges_q;
  logic        miso_q, up_q, dither_q, pwm_q, locked_q, en, wr;
  logic        sclk_rise, sclk_fall, cs_act, sync_rise, restart, win_done;

  // two flops before use; the extra stage only serves edge detection
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sclk_s <= 3'h0;
      cs_s   <= 3'h7;
      mosi_s <= 2'h0;
      sync_s <= 3'h0;
    end else begin
      sclk_s <= {sclk_s[1:0], link.sclk};
      cs_s   <= {cs_s[1:0], link.cs_n};
      mosi_s <= {mosi_s[0], link.mosi};
      sync_s <= {sync_s[1:0], link.pwm_sync};
    end
  end

  assign sclk_rise = sclk_s[1] & ~sclk_s[2];
  assign sclk_fall = ~sclk_s[1] & sclk_s[2];
  assign cs_act    = ~cs_s[1];
  assign sync_rise = sync_s[1] & ~sync_s[2];
  assign rx_nx     = {rx_q[22:0], mosi_s[1]};
  assign wr        = cs_act & sclk_rise & ~rx_nx[23] &
                     (bit_q == 5'(pgs_pkg::FRAME_BITS - 1));
  assign en  = pwmg_q[pgs_pkg::EN_BIT];
  assign dir = pwmg_q[pgs_pkg::DIR_LSB +: 2];
  assign src = pwmg_q[pgs_pkg::SRC_LSB +: 3];

  // frame: read flag, 7-bit address, 16-bit data, msb first
  always_ff @(posedge aclk) begin
    if (!aresetn || !cs_act) begin
      bit_q <= 5'h00;
    end else if (sclk_rise) begin
      bit_q <= bit_q + 5'h01;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_q <= 24'h000000;
    end else if (cs_act && sclk_rise) begin
      rx_q <= rx_nx;
    end
  end

  always_comb begin
    rdv = 16'h0000;
    case (rx_nx[6:0])
      pgs_pkg::A_PWMG: rdv = pwmg_q;
      pgs_pkg::A_CFG1: rdv = cfg1_q;
      pgs_pkg::A_DRV:  rdv = drv_q;
      pgs_pkg::A_PRD:  rdv = {1'b0, meas_q};
      pgs_pkg::A_SYS:  rdv = sys_q;
      default:         rdv = 16'h0000;
    endcase
    rdv[pgs_pkg::PAR_BIT] = parity_on & pgs_pkg::par15(rdv);
  end

  // miso moves on falling sclk so the controller samples it on rising
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_q   <= 16'h0000;
      miso_q <= 1'b0;
    end else if (!cs_act) begin
      miso_q <= 1'b0;
    end else if (sclk_rise && bit_q == 5'(pgs_pkg::HDR_BITS - 1)) begin
      tx_q <= rdv;
    end else if (sclk_fall && bit_q >= 5'(pgs_pkg::HDR_BITS)) begin
      miso_q <= tx_q[15];
      tx_q   <= {tx_q[14:0], 1'b0};
    end
  end
  assign link.miso = miso_q;
  // parity bit and reserved bits are masked on write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pwmg_q <= pgs_pkg::PWMG_RST;
      cfg1_q <= PWM_OVER_LINK ? pgs_pkg::CFG1_RST_P
                              : pgs_pkg::CFG1_RST_S;
      drv_q  <= pgs_pkg::DRV_RST;
      sys_q  <= pgs_pkg::SYS_RST;
    end else if (wr) begin
      case (rx_nx[22:16])
        pgs_pkg::A_PWMG: pwmg_q <= rx_nx[15:0] & pgs_pkg::PWMG_MASK;
        pgs_pkg::A_CFG1: cfg1_q <= rx_nx[15:0] & pgs_pkg::CFG1_MASK;
        pgs_pkg::A_DRV:  drv_q  <= rx_nx[15:0] & pgs_pkg::DRV_MASK;
        pgs_pkg::A_SYS:  sys_q  <= rx_nx[15:0] & pgs_pkg::SYS_MASK;
        default: ;
      endcase
    end
  end

  assign gen_on              = pwmg_q[pgs_pkg::EN_BIT];
  assign counter_direction   = dir;
  assign spread_spectrum_off = cfg1_q[pgs_pkg::SSC_BIT];
  assign drive_scheme        = cfg1_q[pgs_pkg::MODE_LSB +: 2];
  assign parity_on           = sys_q[pgs_pkg::PEN_BIT];
  assign pwm_count           = cnt_q;
  assign pwm_out             = pwm_q;
  assign osc_locked          = locked_q;

  // spread spectrum dithers the top by one count each turn
  assign top     = period_q - {15'h0000, dither_q};
  assign restart = sync_rise &&
                   (src == pgs_pkg::SRC_PERIOD || src == pgs_pkg::SRC_BOTH);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q    <= 16'h0000;
      up_q     <= 1'b1;
      dither_q <= 1'b0;
    end else if (!en || restart) begin
      cnt_q <= 16'h0000;
      up_q  <= 1'b1;
    end else begin
      case (dir)
        pgs_pkg::DIR_UPDN: begin
          if (up_q && cnt_q >= top) begin
            up_q  <= 1'b0;
            cnt_q <= cnt_q - 16'h0001;
          end else if (up_q) begin
            cnt_q <= cnt_q + 16'h0001;
          end else if (cnt_q == 16'h0000) begin
            up_q     <= 1'b1;
            cnt_q    <= 16'h0001;
            dither_q <= ~spread_spectrum_off & ~dither_q;
          end else begin
            cnt_q <= cnt_q - 16'h0001;
          end
        end
        pgs_pkg::DIR_UP: begin
          if (cnt_q >= top) begin
            cnt_q    <= 16'h0000;
            dither_q <= ~spread_spectrum_off & ~dither_q;
          end else begin
            cnt_q <= cnt_q + 16'h0001;
          end
        end
        pgs_pkg::DIR_DN: begin
          if (cnt_q == 16'h0000) begin
            cnt_q    <= top;
            dither_q <= ~spread_spectrum_off & ~dither_q;
          end else begin
            cnt_q <= cnt_q - 16'h0001;
          end
        end
        default: cnt_q <= cnt_q;
      endcase
    end
  end

  // fixed half-period duty; duty registers live elsewhere
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pwm_q <= 1'b0;
    end else if (!en) begin
      pwm_q <= 1'b0;
    end else if (dir != 2'h3) begin
      pwm_q <= cnt_q < {1'b0, top[15:1]};
    end
  end
  // sync pulse period in aclk cycles, saturating
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      per_cnt_q <= 16'h0000;
      meas_q    <= 15'h0000;
      period_q  <= pgs_pkg::SYNC_CYC16;
    end else begin
      if (sync_rise) begin
        per_cnt_q <= 16'h0001;
      end else if (per_cnt_q != 16'h7FFF) begin
        per_cnt_q <= per_cnt_q + 16'h0001;
      end
      if (sync_rise && src == pgs_pkg::SRC_MEAS) begin
        meas_q <= per_cnt_q[14:0];
      end
      if (restart) begin
        period_q <= per_cnt_q;
      end
    end
  end

  // sclk window counts aclk only inside frames; idle gaps are excluded
  assign win_exp  = pgs_pkg::sclk_window(pwmg_q[pgs_pkg::RATE_LSB +: 3],
                                         pwmg_q[pgs_pkg::NCYC_LSB +: 2]);
  assign win_tol  = (pwmg_q[pgs_pkg::NCYC_LSB +: 2] == pgs_pkg::NCYC_64) ?
                    (win_exp >> 6) : (win_exp >> 7);
  assign win_done = (src == pgs_pkg::SRC_SCLK) && sclk_rise &&
                    (edges_q == pgs_pkg::sclk_edges(
                       pwmg_q[pgs_pkg::NCYC_LSB +: 2]));

  always_ff @(posedge aclk) begin
    if (!aresetn || src != pgs_pkg::SRC_SCLK || win_done) begin
      edges_q <= 10'h000;
      win_q   <= 16'h0000;
    end else begin
      if (sclk_rise) begin
        edges_q <= edges_q + 10'h001;
      end
      if (cs_act && edges_q != 10'h000 && win_q != 16'hFFFF) begin
        win_q <= win_q + 16'h0001;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      locked_q <= 1'b0;
    end else begin
      case (src)
        pgs_pkg::SRC_LOCK, pgs_pkg::SRC_BOTH: begin
          if (sync_rise) begin
            locked_q <= pgs_pkg::near(per_cnt_q, pgs_pkg::SYNC_CYC16,
                                      pgs_pkg::SYNC_TOL16);
          end
        end
        pgs_pkg::SRC_SCLK: begin
          if (win_done) begin
            locked_q <= pgs_pkg::near(win_q, win_exp,
                                      win_tol);
          end
        end
        default: locked_q <= 1'b0;
      endcase
    end
  end
endmodule // pgs_device
`default_nettype wire

//--- rtl/pgs_host.sv
// pgs_host: controller end; AXI4-Lite registers drive link frames and sync.
// assumes the generator end answers miso within half an sclk period.
`default_nettype none
module pgs_host (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  pgs_link_if.host         link
);
  typedef enum logic {PGS_IDLE, PGS_RUN} pgs_hstate_type;
  pgs_hstate_type state_q;
  logic        wr_go;
  logic        rd_go;
  logic        start;
  logic [1:0]  miso_s;
  logic [23:0] sh_q;
  logic [15:0] rx_q;
  logic [4:0]  bitn_q;
  logic [3:0]  half_q;
  logic        sclk_q;
  logic        cs_n_q;
  logic        mosi_q;
  logic        sync_en_q;
  logic [15:0] scnt_q;
  logic        sync_q;

  assign wr_go = s_axi_awvalid & s_axi_wvalid & ~s_axi_awready &
                 ~s_axi_bvalid;
  assign rd_go = s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
  // a command written while busy is dropped; software polls busy
  assign start = wr_go && s_axi_awaddr == pgs_pkg::H_CMD &&
                 s_axi_wstrb[2:0] == 3'h7 && state_q == PGS_IDLE;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= pgs_pkg::RESP_OK;
      sync_en_q     <= 1'b0;
    end else begin
      s_axi_awready <= wr_go;
      s_axi_wready  <= wr_go;
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (s_axi_awaddr == pgs_pkg::H_CMD ||
                         s_axi_awaddr == pgs_pkg::H_SYNC) ?
                        pgs_pkg::RESP_OK : pgs_pkg::RESP_ERR;
        if (s_axi_awaddr == pgs_pkg::H_SYNC && s_axi_wstrb[0]) begin
          sync_en_q <= s_axi_wdata[0];
        end
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= pgs_pkg::RESP_OK;
    end else begin
      s_axi_arready <= rd_go;
      if (rd_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= pgs_pkg::RESP_OK;
        case (s_axi_araddr)
          pgs_pkg::H_CMD:  s_axi_rdata <= 32'h00000000;
          pgs_pkg::H_STAT: s_axi_rdata <= {15'h0000,
                                           state_q == PGS_RUN, rx_q};
          pgs_pkg::H_SYNC: s_axi_rdata <= {31'h00000000, sync_en_q};
          default: begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= pgs_pkg::RESP_ERR;
          end
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      miso_s <= 2'h0;
    end else begin
      miso_s <= {miso_s[0], link.miso};
    end
  end

  // sclk divided from aclk; rate must match the generator's rate field
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= PGS_IDLE;
      sh_q    <= 24'h000000;
      rx_q    <= 16'h0000;
      bitn_q  <= 5'h00;
      half_q  <= 4'h0;
      sclk_q  <= 1'b0;
      cs_n_q  <= 1'b1;
      mosi_q  <= 1'b0;
    end else begin
      case (state_q)
        PGS_IDLE: begin
          if (start) begin
            state_q <= PGS_RUN;
            sh_q    <= s_axi_wdata[23:0];
            mosi_q  <= s_axi_wdata[23];
            cs_n_q  <= 1'b0;
            bitn_q  <= 5'h00;
            half_q  <= 4'h0;
          end
        end
        PGS_RUN: begin
          if (half_q == 4'(pgs_pkg::SCLK_HALF - 1)) begin
            half_q <= 4'h0;
            sclk_q <= ~sclk_q;
            if (!sclk_q) begin
              rx_q <= {rx_q[14:0], miso_s[1]};
            end else if (bitn_q == 5'(pgs_pkg::FRAME_BITS - 1)) begin
              cs_n_q  <= 1'b1;
              mosi_q  <= 1'b0;
              state_q <= PGS_IDLE;
            end else begin
              bitn_q <= bitn_q + 5'h01;
              sh_q   <= {sh_q[22:0], 1'b0};
              mosi_q <= sh_q[22];
            end
          end else begin
            half_q <= half_q + 4'h1;
          end
        end
        default: state_q <= PGS_IDLE;
      endcase
    end
  end

  // 20 kHz sync pulse, the only rate generator codes 5 and 6 lock to; a pulse
  // under way when sync is switched off still runs to its full width
  always_ff @(posedge aclk) begin
    if (!aresetn || (!sync_en_q && !sync_q)) begin
      scnt_q <= 16'h0000;
      sync_q <= 1'b0;
    end else begin
      scnt_q <= (scnt_q == pgs_pkg::SYNC_CYC16 - 16'h0001) ?
                16'h0000 : scnt_q + 16'h0001;
      sync_q <= scnt_q < 16'(pgs_pkg::SYNC_W);
    end
  end

  assign link.sclk     = sclk_q;
  assign link.cs_n     = cs_n_q;
  assign link.mosi     = mosi_q;
  assign link.pwm_sync = sync_q;
endmodule // pgs_host
`default_nettype wire

//--- rtl/pgs_link_if.sv
// pgs_link_if: serial link and sync pulse between controller and generator.
// assumes both ends sample these wires with their own aclk.
`default_nettype none
interface pgs_link_if;
  logic sclk;
  logic cs_n;
  logic mosi;
  logic miso;
  logic pwm_sync;
  modport dev (input sclk, input cs_n, input mosi, input pwm_sync,
               output miso);
  modport host (output sclk, output cs_n, output mosi, output pwm_sync,
                input miso);
endinterface
`default_nettype wire

//--- rtl/pgs_pkg.sv
// pgs_pkg: constants shared by the generator end and the controller end.
// assumes a 25 MHz aclk on both ends.
`default_nettype none
package pgs_pkg;
  localparam int CLK_HZ     = 25_000_000;
  localparam int SYNC_HZ    = 20_000;
  localparam int SYNC_CYC   = CLK_HZ / SYNC_HZ;
  localparam int SYNC_TOL   = SYNC_CYC / 100;
  localparam int SYNC_W     = 8;
  localparam int SCLK_HALF  = 10;
  localparam int FRAME_BITS = 24;
  localparam int HDR_BITS   = 8;
  localparam logic [15:0] SYNC_CYC16 = 16'(SYNC_CYC);
  localparam logic [15:0] SYNC_TOL16 = 16'(SYNC_TOL);
  // register offsets on the link
  localparam logic [6:0] A_PWMG = 7'h1D;
  localparam logic [6:0] A_CFG1 = 7'h20;
  localparam logic [6:0] A_DRV  = 7'h22;
  localparam logic [6:0] A_PRD  = 7'h24;
  localparam logic [6:0] A_SYS  = 7'h3F;
  // field positions
  localparam int PAR_BIT  = 15;
  localparam int EN_BIT   = 10;
  localparam int DIR_LSB  = 8;
  localparam int SRC_LSB  = 5;
  localparam int RATE_LSB = 2;
  localparam int NCYC_LSB = 0;
  localparam int SSC_BIT  = 2;
  localparam int MODE_LSB = 0;
  localparam int PEN_BIT  = 6;
  // writable bits and reset values
  localparam logic [15:0] PWMG_MASK  = 16'h07FF;
  localparam logic [15:0] CFG1_MASK  = 16'h0007;
  localparam logic [15:0] DRV_MASK   = 16'h0FF3;
  localparam logic [15:0] SYS_MASK   = 16'h01F8;
  localparam logic [15:0] PWMG_RST   = 16'h0000;
  localparam logic [15:0] CFG1_RST_P = 16'h0007;
  localparam logic [15:0] CFG1_RST_S = 16'h0004;
  localparam logic [15:0] DRV_RST    = 16'h0000;
  localparam logic [15:0] SYS_RST    = 16'h0000;
  // field codes
  localparam logic [1:0] DIR_UPDN   = 2'h0;
  localparam logic [1:0] DIR_UP     = 2'h1;
  localparam logic [1:0] DIR_DN     = 2'h2;
  localparam logic [2:0] SRC_MEAS   = 3'h1;
  localparam logic [2:0] SRC_PERIOD = 3'h2;
  localparam logic [2:0] SRC_LOCK   = 3'h5;
  localparam logic [2:0] SRC_BOTH   = 3'h6;
  localparam logic [2:0] SRC_SCLK   = 3'h7;
  localparam logic [1:0] NCYC_64    = 2'h3;
  // controller registers on AXI4-Lite
  localparam logic [3:0] H_CMD  = 4'h0;
  localparam logic [3:0] H_STAT = 4'h4;
  localparam logic [3:0] H_SYNC = 4'h8;
  localparam logic [1:0] RESP_OK  = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;

  function automatic logic par15(input logic [15:0] v);
    return ^v[14:0];
  endfunction

  function automatic logic [9:0] sclk_edges(input logic [1:0] ncyc);
    return 10'h200 >> ncyc;
  endfunction

  // aclk cycles expected over the sync window: 64 cycles, scaled up
  function automatic logic [15:0] sclk_window(input logic [2:0] rate,
                                              input logic [1:0] ncyc);
    logic [15:0] base;
    case (rate)
      3'h0:    base = 16'h0640;
      3'h1:    base = 16'h0500;
      3'h2:    base = 16'h0320;
      3'h3:    base = 16'h0280;
      3'h4:    base = 16'h0190;
      3'h5:    base = 16'h0140;
      3'h6:    base = 16'h00C8;
      default: base = 16'h00A0;
    endcase
    return base << (2'h3 - ncyc);
  endfunction

  function automatic logic near(input logic [15:0] v,
                                input logic [15:0] e,
                                input logic [15:0] t);
    return ({1'b0, v} + {1'b0, t} >= {1'b0, e}) &&
           ({1'b0, v} <= {1'b0, e} + {1'b0, t});
  endfunction
endpackage
`default_nettype wire

//--- tb/pgs_link_properties.sv
// pgs_link_properties: timing of the link wires between the two ends.
// assumes aclk at 25 MHz, sclk half period of 10 aclk, sync every 1250.
`default_nettype none
module pgs_link_properties (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic miso,
  input wire logic pwm_sync
);
  logic        sync_q;
  logic        sclk_q;
  logic [11:0] gap_q;
  logic [5:0]  rises_q;
  logic [4:0]  run_q;

  always_ff @(posedge aclk) begin
    sync_q <= aresetn & pwm_sync;
    sclk_q <= aresetn & sclk;
  end

  // saturates so a re-enabled pulse train is not judged on its first gap
  always_ff @(posedge aclk) begin
    if (!aresetn)
      gap_q <= 12'hFFF;
    else if (pwm_sync && !sync_q)
      gap_q <= 12'h001;
    else if (gap_q != 12'hFFF)
      gap_q <= gap_q + 12'h001;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || cs_n)
      rises_q <= 6'h00;
    else if (sclk && !sclk_q)
      rises_q <= rises_q + 6'h01;
  end

  // length of the present sclk level, saturating; long idle reads 31
  always_ff @(posedge aclk) begin
    if (!aresetn)
      run_q <= 5'h1F;
    else if (sclk != sclk_q)
      run_q <= 5'h01;
    else if (run_q != 5'h1F)
      run_q <= run_q + 5'h01;
  end

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_sync_pulse;
    pwm_sync[*8] ##1 !pwm_sync;
  endsequence

  a_sclk_idle_low: assert property (cs_n |-> !sclk)
    else $error("sclk high outside a frame");
  a_sclk_high_half: assert property ($fell(sclk) |-> run_q == 5'h0A)
    else $error("sclk high phase not 10 cycles");
  a_sclk_low_half: assert property ($rose(sclk) |-> run_q >= 5'h0A)
    else $error("sclk low phase too short");
  a_mosi_stable: assert property (!cs_n && sclk |-> $stable(mosi))
    else $error("mosi moved while sclk high");
  a_miso_quiet: assert property (cs_n && $past(cs_n, 4) |-> !miso)
    else $error("miso driven outside a frame");
  a_sync_width: assert property ($rose(pwm_sync) |-> s_sync_pulse)
    else $error("sync pulse width not 8 cycles");
  a_sync_period: assert property (
    pwm_sync && !sync_q && gap_q < 12'h514 |-> gap_q == 12'h4E2)
    else $error("sync period not 1250 cycles");
  a_frame_rises: assert property ($rose(cs_n) |-> rises_q == 6'h18)
    else $error("frame did not carry 24 sclk rises");
endmodule // pgs_link_properties
`default_nettype wire

//--- tb/pgs_tb_top.sv
// pgs_tb_top: controller and generator joined on one link, AXI stimulus.
// assumes the package, interface, both ends and the checker compiled first.
`default_nettype none
module pgs_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic        aclk, aresetn;
  logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata, s;
  logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
  logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic        gen_on, pwm_out, osc_locked, spread_spectrum_off, parity_on;
  logic [1:0]  counter_direction, drive_scheme;
  logic [15:0] pwm_count, v, e, w;
  int          num_errors = 0;
  int          comparisons = 0;

  pgs_link_if lk();
  pgs_host u_pgs_host (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .link(lk));
  pgs_device u_pgs_device (.aclk, .aresetn, .link(lk), .gen_on,
    .counter_direction, .pwm_count, .pwm_out, .osc_locked,
    .spread_spectrum_off, .drive_scheme, .parity_on);
  pgs_link_properties chk (.aclk, .aresetn, .sclk(lk.sclk), .cs_n(lk.cs_n),
    .mosi(lk.mosi), .miso(lk.miso), .pwm_sync(lk.pwm_sync));

  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  task automatic final_report();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // masked write value with the parity bit the reader should see
  function automatic logic [15:0] exp_rd(input logic [15:0] d,
                                         input logic [15:0] m,
                                         input logic p);
    logic [15:0] x;
    x = d & m;
    x[15] = p & (^x[14:0]);
    return x;
  endfunction

  task automatic wr(input logic [3:0] a, input logic [31:0] d,
                    output logic [1:0] q);
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid)
        break;
    end
    q = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] d,
                    output logic [1:0] q);
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid)
        break;
    end
    d = s_axi_rdata;
    q = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // one link frame; busy is polled so frames never overlap
  task automatic op(input logic rw, input logic [6:0] a,
                    input logic [15:0] d, output logic [15:0] q);
    logic [1:0]  k;
    logic [31:0] t;
    wr(4'h0, {8'h00, rw, a, d}, k);
    t = 32'h0001_0000;
    while (t[16])
      rd(4'h4, t, k);
    q = t[15:0];
  endtask

  initial begin
    repeat (95000) @(posedge aclk);
    num_errors++;
    final_report();
  end

  initial begin
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hF;
    aresetn = 1'b0;
    e = 16'($urandom(32'h7421EC35));
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    check({11'h000, gen_on, spread_spectrum_off, drive_scheme, parity_on},
          16'h000E);
    op(1'b1, 7'h1D, 16'h0000, v);
    check(v, 16'h0000);
    op(1'b1, 7'h20, 16'h0000, v);
    check(v, 16'h0007);
    for (int i = 0; i < 4; i++) begin
      e = 16'($urandom);
      e[10:5] = {i[0], 2'(i), 3'h0};
      op(1'b0, 7'h1D, e, v);
      op(1'b1, 7'h1D, 16'h0000, v);
      check(v, exp_rd(e, 16'h07FF, 1'b0));
      check({13'h0000, gen_on, counter_direction}, 16'(e[10:8]));
      if (!e[10])
        check({pwm_count[14:0], pwm_out}, 16'h0000);
      w = 16'($urandom);
      w[1:0] = 2'(i);
      op(1'b0, 7'h20, w, v);
      op(1'b1, 7'h20, 16'h0000, v);
      check(v, exp_rd(w, 16'h0007, 1'b0));
      check({13'h0000, spread_spectrum_off, drive_scheme},
            w & 16'h0007);
    end
    op(1'b0, 7'h1D, 16'h0500, v);
    w = pwm_count;
    repeat (50) @(posedge aclk);
    check({15'h0000, pwm_count !== w}, 16'h0001);
    // no-action code mid-count: count and output must freeze
    op(1'b0, 7'h1D, 16'h0700, v);
    w = pwm_count;
    e = {15'h0000, pwm_out};
    repeat (50) @(posedge aclk);
    check(pwm_count, w);
    check({15'h0000, pwm_out}, e);
    op(1'b0, 7'h3F, 16'h0040, v);
    check({15'h0000, parity_on}, 16'h0001);
    op(1'b1, 7'h1D, 16'h0000, v);
    check(v, exp_rd(16'h0700, 16'h07FF, 1'b1));
    op(1'b0, 7'h3F, 16'h0000, v);
    wr(4'hC, 32'h0000_0000, r);
    check({14'h0000, r}, 16'h0002);
    rd(4'hC, s, r);
    check({14'h0000, r}, 16'h0002);
    wr(4'h8, 32'h0000_0001, r);
    for (int c = 0; c < 7; c++) begin
      op(1'b0, 7'h1D, 16'(c << 5), v);
      repeat (3750) @(posedge aclk);
      check({15'h0000, osc_locked},
            {15'h0000, c == 5 || c == 6});
      if (c == 1) begin
        op(1'b1, 7'h24, 16'h0000, v);
        check({15'h0000, v > 16'h04DD && v < 16'h04E7}, 16'h0001);
      end
    end
    wr(4'h8, 32'h0000_0000, r);
    // sclk runs at rate code 1; code 7 first claims the wrong rate
    for (int k = 0; k < 2; k++) begin
      op(1'b0, 7'h1D, k ? 16'h00E7 : 16'h00FF, v);
      repeat (3) op(1'b1, 7'h1D, 16'h0000, v);
      check({15'h0000, osc_locked}, 16'(k));
    end
    final_report();
  end
endmodule // pgs_tb_top
`default_nettype wire
